/* File: inc/fsa_flash_map.svh */
// register offsets, reset values, command codes and flash layout constants
`ifndef FSA_FLASH_MAP_SVH
`define FSA_FLASH_MAP_SVH
// special function register offsets
`define FSA_ADR_CMD      8'hB9
`define FSA_ADR_AKEY     8'hBA
`define FSA_ADR_PKEY     8'hBB
`define FSA_ADR_DATA     8'hBC
`define FSA_ADR_ADRL     8'hC6
`define FSA_ADR_ADRH     8'hC7
// register reset values
`define FSA_RST_CMD      8'h00
`define FSA_RST_AKEY     8'hFF
`define FSA_RST_PKEY     8'hFF
`define FSA_RST_DATA     8'h00
`define FSA_RST_ADR      8'h00
// command codes
`define FSA_CMD_WRITE    8'h01
`define FSA_CMD_ERASE_PG 8'h02
`define FSA_CMD_ERASE_AL 8'h03
`define FSA_CMD_READ     8'h04
`define FSA_CMD_VERIFY   8'h0F
// result codes left in the command register
`define FSA_RES_OK       8'h00
`define FSA_RES_FAIL     8'h01
// access key value, arbitrary
`define FSA_ACCESS_KEY   8'hA5
// flash layout
`define FSA_ERASED       8'hFF
`define FSA_LAST_PAGE    7'h7B
`define FSA_FW_BASE      16'hF800
`define FSA_RSV_BASE     16'hF7EB
`define FSA_RSV_LAST     16'hF7FF
`define FSA_SKEY_ADR     16'hF7EB
`define FSA_RP_BASE      16'hF7EC
`define FSA_WP_BASE      16'hF7F0
`define FSA_PAGE_LSB     9
`endif

/* File: inc/fsa_pkg.sv */
// types shared by the flash access and protection block
package fsa_pkg;
   typedef enum logic [2:0] {
      FSA_LOAD,
      FSA_IDLE,
      FSA_FETCH,
      FSA_EVAL,
      FSA_ERASE,
      FSA_DONE
   } fsa_state_t;
endpackage

/* File: hdl/fsa_flash_array.sv */
// flash byte array with registered read data
module fsa_flash_array (
   input  wire logic        clk_in,     // core clock
   input  wire logic        ce_in,      // clock enable
   input  wire logic [15:0] addr_in,    // byte address
   input  wire logic        we_in,      // write strobe
   input  wire logic [7:0]  wdata_in,   // write byte
   output logic      [7:0]  rdata_out   // read byte, one cycle later
);
   logic [7:0] mem_r [0:65535];

   // array powers up erased, as a blank part would
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem_r[i] = 8'hFF;
      end
   end

   // single port, read-before-write
   always_ff @(posedge clk_in) begin
      if (ce_in) begin
         if (we_in) begin
            mem_r[addr_in] <= wdata_in;
         end
         rdata_out <= mem_r[addr_in];
      end
   end
endmodule

/* File: hdl/fsa_flash_ctrl.sv */
// flash access and protection controller behind the core's special function registers
`include "fsa_flash_map.svh"
module fsa_flash_ctrl
   import fsa_pkg::*;
(
   input  wire logic       clk_in,         // core clock, 100 MHz
   input  wire logic       rst_b_in,       // synchronous reset, active low
   input  wire logic       ce_in,          // clock enable, freezes state when low
   input  wire logic [7:0] sfr_addr_in,    // special function register address
   input  wire logic [7:0] sfr_wdata_in,   // write data
   input  wire logic       sfr_we_in,      // write strobe
   input  wire logic       sfr_re_in,      // read strobe
   output logic      [7:0] sfr_rdata_out,  // read data, one cycle after strobe
   output logic            cpu_hold_out,   // hold program counter
   output logic            irq_defer_out   // defer interrupt service
);
   // page number from the upper address bits
   function automatic logic [6:0] page_of(input logic [15:0] a);
      page_of = a[15:`FSA_PAGE_LSB];
   endfunction

   fsa_state_t  st_r;
   logic [7:0]  cmd_r, akey_r, pkey_r, data_r, adrl_r, adrh_r;
   logic [7:0]  op_r, skey_r;
   logic [15:0] cnt_r, end_r;
   logic [127:0] wp_r;
   logic [31:0] rp_r;
   logic        reload_r, ld_v_r;
   logic [15:0] ld_a_r;
   logic [7:0]  mem_rdata;

   // decode of the register bus
   wire         sfr_idle  = (st_r == FSA_IDLE);
   wire         wr_cmd    = sfr_we_in && sfr_idle && (sfr_addr_in == `FSA_ADR_CMD);
   wire         wr_akey   = sfr_we_in && sfr_idle && (sfr_addr_in == `FSA_ADR_AKEY);
   wire         wr_pkey   = sfr_we_in && sfr_idle && (sfr_addr_in == `FSA_ADR_PKEY);
   wire         wr_data   = sfr_we_in && sfr_idle && (sfr_addr_in == `FSA_ADR_DATA);
   wire         wr_adrl   = sfr_we_in && sfr_idle && (sfr_addr_in == `FSA_ADR_ADRL);
   wire         wr_adrh   = sfr_we_in && sfr_idle && (sfr_addr_in == `FSA_ADR_ADRH);
   wire [15:0]  addr      = {adrh_r, adrl_r};
   wire [6:0]   pg        = page_of(addr);

   // command decode; unknown codes are refused
   wire         is_wr     = (sfr_wdata_in == `FSA_CMD_WRITE);
   wire         is_ep     = (sfr_wdata_in == `FSA_CMD_ERASE_PG);
   wire         is_ea     = (sfr_wdata_in == `FSA_CMD_ERASE_AL);
   wire         is_rd     = (sfr_wdata_in == `FSA_CMD_READ);
   wire         is_vf     = (sfr_wdata_in == `FSA_CMD_VERIFY);

   // access checks against key, firmware area and protection bits
   wire         akey_ok   = (akey_r == `FSA_ACCESS_KEY);
   wire         pkey_ok   = (pkey_r == skey_r);
   wire         in_fw     = (addr >= `FSA_FW_BASE);
   wire         in_rsv    = (addr >= `FSA_RSV_BASE) && !in_fw;
   wire         touch_rsv = is_ep ? (pg == `FSA_LAST_PAGE) : in_rsv;
   wire         rd_ok     = !in_fw && rp_r[pg[6:2]];
   wire         wr_ok     = !in_fw && wp_r[pg] && (!touch_rsv || pkey_ok);
   wire         cmd_ok    = akey_ok && (((is_rd || is_vf) && rd_ok)
                                     || ((is_wr || is_ep) && wr_ok) || is_ea);

   // mass erase spares the protection bytes unless the protection key matches
   wire [15:0]  ea_end    = pkey_ok ? `FSA_RSV_LAST : (`FSA_RSV_BASE - 16'h0001);

   // erase steps skip write-protected pages and never reach firmware
   wire         er_ok     = wp_r[page_of(cnt_r)] && (cnt_r < `FSA_FW_BASE);

   // array port selection
   wire         use_cnt   = (st_r == FSA_LOAD) || (st_r == FSA_ERASE);
   wire [15:0]  mem_addr  = use_cnt ? cnt_r : addr;
   wire         mem_we    = ((st_r == FSA_EVAL) && (op_r == `FSA_CMD_WRITE))
                         || ((st_r == FSA_ERASE) && er_ok);
   wire [7:0]   mem_wdata = (st_r == FSA_ERASE) ? `FSA_ERASED
                                                : (mem_rdata & data_r);

   // register read multiplexer, unmapped reads give zero
   wire [7:0]   rd_mux    = (sfr_addr_in == `FSA_ADR_CMD)  ? cmd_r  :
                            (sfr_addr_in == `FSA_ADR_AKEY) ? akey_r :
                            (sfr_addr_in == `FSA_ADR_PKEY) ? pkey_r :
                            (sfr_addr_in == `FSA_ADR_DATA) ? data_r :
                            (sfr_addr_in == `FSA_ADR_ADRL) ? adrl_r :
                            (sfr_addr_in == `FSA_ADR_ADRH) ? adrh_r : 8'h00;

   fsa_flash_array u_array (
      .clk_in    (clk_in),
      .ce_in     (ce_in),
      .addr_in   (mem_addr),
      .we_in     (mem_we),
      .wdata_in  (mem_wdata),
      .rdata_out (mem_rdata)
   );

   // software registers; the controller owns them while busy
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         akey_r <= `FSA_RST_AKEY;
         pkey_r <= `FSA_RST_PKEY;
         adrl_r <= `FSA_RST_ADR;
         adrh_r <= `FSA_RST_ADR;
      end else if (ce_in) begin
         if (wr_akey) akey_r <= sfr_wdata_in;
         else if (st_r == FSA_DONE) akey_r <= `FSA_RST_AKEY;
         if (wr_pkey) pkey_r <= sfr_wdata_in;
         if (wr_adrl) adrl_r <= sfr_wdata_in;
         if (wr_adrh) adrh_r <= sfr_wdata_in;
      end
   end

   // read data and the core hold, both from flops
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         sfr_rdata_out <= 8'h00;
         cpu_hold_out  <= 1'b1;
         irq_defer_out <= 1'b1;
      end else if (ce_in) begin
         if (sfr_re_in) sfr_rdata_out <= rd_mux;
         cpu_hold_out  <= !sfr_idle || wr_cmd;
         irq_defer_out <= !sfr_idle || wr_cmd;
      end
   end

   // protection image capture, one cycle behind the load address
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         ld_v_r <= 1'b0;
         ld_a_r <= 16'h0000;
         wp_r   <= '0;
         rp_r   <= 32'h0000_0000;
         skey_r <= 8'h00;
      end else if (ce_in) begin
         ld_v_r <= (st_r == FSA_LOAD);
         ld_a_r <= cnt_r;
         if (ld_v_r) begin
            if (ld_a_r >= `FSA_WP_BASE)
               wp_r[{ld_a_r[3:0], 3'h0} +: 8] <= mem_rdata;
            else if (ld_a_r >= `FSA_RP_BASE)
               rp_r[{ld_a_r[1:0], 3'h0} +: 8] <= mem_rdata;
            else if (ld_a_r == `FSA_SKEY_ADR)
               skey_r <= mem_rdata;
         end
      end
   end

   // operation sequencer
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         st_r     <= FSA_LOAD;
         cnt_r    <= `FSA_RSV_BASE;
         end_r    <= 16'h0000;
         op_r     <= 8'h00;
         cmd_r    <= `FSA_RST_CMD;
         data_r   <= `FSA_RST_DATA;
         reload_r <= 1'b0;
      end else if (ce_in) begin
         if (wr_data) data_r <= sfr_wdata_in;
         unique case (st_r)
            FSA_LOAD: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == `FSA_RSV_LAST) st_r <= FSA_IDLE;
            end
            FSA_IDLE: begin
               if (wr_cmd) begin
                  op_r     <= sfr_wdata_in;
                  cmd_r    <= sfr_wdata_in;
                  reload_r <= 1'b0;
                  if (!cmd_ok) begin
                     cmd_r <= `FSA_RES_FAIL;
                     st_r  <= FSA_DONE;
                  end else if (is_ep) begin
                     cnt_r <= {pg, 9'h000};
                     end_r <= {pg, 9'h1FF};
                     st_r  <= FSA_ERASE;
                  end else if (is_ea) begin
                     cnt_r <= 16'h0000;
                     end_r <= ea_end;
                     st_r  <= FSA_ERASE;
                  end else begin
                     st_r  <= FSA_FETCH;
                  end
               end
            end
            FSA_FETCH: st_r <= FSA_EVAL;
            FSA_EVAL: begin
               cmd_r <= `FSA_RES_OK;
               if (op_r == `FSA_CMD_READ) data_r <= mem_rdata;
               if (op_r == `FSA_CMD_VERIFY && mem_rdata != data_r) cmd_r <= `FSA_RES_FAIL;
               reload_r <= (op_r == `FSA_CMD_WRITE) && in_rsv;
               st_r     <= FSA_DONE;
            end
            FSA_ERASE: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == end_r) begin
                  cmd_r    <= `FSA_RES_OK;
                  reload_r <= (end_r >= `FSA_RSV_BASE);
                  st_r     <= FSA_DONE;
               end
            end
            FSA_DONE: begin
               // a changed protection image takes effect before the next command
               cnt_r <= `FSA_RSV_BASE;
               st_r  <= reload_r ? FSA_LOAD : FSA_IDLE;
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in || !ce_in);

   property p_fw_locked;
      mem_we |-> (mem_addr < `FSA_FW_BASE);
   endproperty
   a_fw_locked: assert property (p_fw_locked) else $error("firmware area written");

   property p_erase_page;
      (mem_we && st_r == FSA_ERASE && op_r == `FSA_CMD_ERASE_PG)
         |-> (mem_wdata == 8'hFF) && (page_of(mem_addr) == pg);
   endproperty
   a_erase_page: assert property (p_erase_page) else $error("erase left its page");

   property p_wp_honoured;
      mem_we |-> wp_r[page_of(mem_addr)];
   endproperty
   a_wp_honoured: assert property (p_wp_honoured) else $error("protected page written");

   property p_rp_honoured;
      (st_r == FSA_EVAL && op_r == `FSA_CMD_READ) |-> rp_r[pg[6:2]];
   endproperty
   a_rp_honoured: assert property (p_rp_honoured) else $error("protected group read");

   property p_prot_key;
      (mem_we && mem_addr >= `FSA_RSV_BASE) |-> pkey_ok;
   endproperty
   a_prot_key: assert property (p_prot_key) else $error("protection changed without key");

   property p_prog_clears;
      (mem_we && st_r == FSA_EVAL) |-> ((mem_wdata & ~mem_rdata) == 8'h00);
   endproperty
   a_prog_clears: assert property (p_prog_clears) else $error("program set a bit");

   property p_key_clear;
      (st_r == FSA_DONE) |=> (akey_r == 8'hFF) && (st_r != FSA_DONE);
   endproperty
   a_key_clear: assert property (p_key_clear) else $error("access key not cleared");

   sequence s_cmd_go;
      wr_cmd && cmd_ok && !is_ep && !is_ea;
   endsequence
   sequence s_op_run;
      cpu_hold_out && st_r == FSA_FETCH ##1 cpu_hold_out && st_r == FSA_EVAL;
   endsequence
   property p_hold;
      s_cmd_go |=> s_op_run ##1 (cpu_hold_out && irq_defer_out);
   endproperty
   a_hold: assert property (p_hold) else $error("core not held during operation");

   sequence s_read_go;
      wr_cmd && cmd_ok && is_rd;
   endsequence
   property p_read_data;
      s_read_go |=> ##1 (st_r == FSA_EVAL) ##1 (data_r == $past(mem_rdata));
   endproperty
   a_read_data: assert property (p_read_data) else $error("read byte not captured");
endmodule

/* File: testbench/fsa_core_model.sv */
// processor core model: register accesses and flash commands with stall handling
`include "fsa_flash_map.svh"
module fsa_core_model (
   input  wire logic       clk_in,     // core clock
   input  wire logic [7:0] rdata_in,   // read data from the block
   input  wire logic       hold_in,    // stall request from the block
   output logic      [7:0] addr_out,   // register address
   output logic      [7:0] wdata_out,  // write data
   output logic            we_out,     // write strobe
   output logic            re_out      // read strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      we_out = 1'b0;
      re_out = 1'b0;
   end
   // released lines show the inverse so a stale value never looks valid
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= d;
      we_out    <= 1'b1;
      @(posedge clk_in);
      we_out    <= 1'b0;
      addr_out  <= ~a;
      wdata_out <= ~d;
   endtask
   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      re_out   <= 1'b1;
      @(posedge clk_in);
      re_out   <= 1'b0;
      addr_out <= ~a;
      #1;
      d = rdata_in;
   endtask
   // one command; the core stalls until hold drops, the bench's cycle guard ends a hang first
   task automatic flash_op(input logic [7:0] key, input logic [7:0] cmd,
                           input logic [15:0] adr, input logic [7:0] dat,
                           output logic held, output logic [7:0] res);
      int n;
      sfr_wr(`FSA_ADR_AKEY, key);
      sfr_wr(`FSA_ADR_ADRH, adr[15:8]);
      sfr_wr(`FSA_ADR_ADRL, adr[7:0]);
      sfr_wr(`FSA_ADR_DATA, dat);
      sfr_wr(`FSA_ADR_CMD, cmd);
      @(posedge clk_in);
      #1;
      held = hold_in;
      n = 0;
      while (hold_in !== 1'b0 && n < 100000) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      sfr_rd(`FSA_ADR_CMD, res);
   endtask
endmodule

/* File: testbench/fsa_flash_tb.sv */
// self-checking bench for the flash access and protection controller
`include "fsa_flash_map.svh"
module flash_sfr_access_protection_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_in;
   logic       rst_b_in;
   logic       ce_in;
   logic [7:0] sfr_addr;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic       sfr_we;
   logic       sfr_re;
   logic       cpu_hold;
   logic       irq_defer;
   int         n_mismatch;
   int         samples_checked;
   int         cycles;
   logic       held;
   logic [7:0] res;
   logic [7:0] v;
   logic [7:0] rst_adr [7];
   logic [7:0] rst_val [7];
   localparam logic [7:0] K = `FSA_ACCESS_KEY;
   fsa_flash_ctrl fsa_flash_ctrl_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
      .sfr_addr_in(sfr_addr), .sfr_wdata_in(sfr_wdata), .sfr_we_in(sfr_we),
      .sfr_re_in(sfr_re), .sfr_rdata_out(sfr_rdata), .cpu_hold_out(cpu_hold),
      .irq_defer_out(irq_defer));
   fsa_core_model fsa_core_model_inst (.clk_in(clk_in), .rdata_in(sfr_rdata),
      .hold_in(cpu_hold), .addr_out(sfr_addr), .wdata_out(sfr_wdata), .we_out(sfr_we),
      .re_out(sfr_re));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // hang guard, above the ~65000 cycles the sequence needs with its mass erase
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic op(input logic [7:0] key, input logic [7:0] cmd, input logic [15:0] adr,
                     input logic [7:0] dat, input logic [7:0] exp);
      fsa_core_model_inst.flash_op(key, cmd, adr, dat, held, res);
      chk("stall", {7'h00, held}, 8'h01);
      chk("result", res, exp);
      fsa_core_model_inst.sfr_rd(`FSA_ADR_AKEY, v);
      chk("key cleared", v, `FSA_RST_AKEY);
   endtask
   task automatic rdback(input logic [15:0] adr, input logic [7:0] exp);
      op(K, `FSA_CMD_READ, adr, 8'h00, `FSA_RES_OK);
      fsa_core_model_inst.sfr_rd(`FSA_ADR_DATA, v);
      chk("flash byte", v, exp);
   endtask
   initial begin
      rst_b_in = 1'b0;
      ce_in = 1'b1;
      n_mismatch = 0;
      samples_checked = 0;
      cycles = 0;
      rst_adr = '{`FSA_ADR_CMD, `FSA_ADR_AKEY, `FSA_ADR_PKEY, `FSA_ADR_DATA, `FSA_ADR_ADRL,
                  `FSA_ADR_ADRH, 8'h50};
      rst_val = '{`FSA_RST_CMD, `FSA_RST_AKEY, `FSA_RST_PKEY, `FSA_RST_DATA, `FSA_RST_ADR,
                  `FSA_RST_ADR, 8'h00};
      repeat (4) @(posedge clk_in);
      rst_b_in <= 1'b1;
      #1;
      chk("hold in reset", {7'h00, cpu_hold}, 8'h01);
      chk("defer in reset", {7'h00, irq_defer}, 8'h01);
      // protection image loads first; no access until the stall drops
      for (int i = 0; i < 100 && cpu_hold !== 1'b0; i++) begin
         @(posedge clk_in);
         #1;
      end
      chk("hold released", {7'h00, cpu_hold}, 8'h00);
      chk("defer released", {7'h00, irq_defer}, 8'h00);
      foreach (rst_adr[i]) begin
         fsa_core_model_inst.sfr_rd(rst_adr[i], v);
         chk("reset value", v, rst_val[i]);
      end
      fsa_core_model_inst.sfr_wr(`FSA_ADR_ADRL, 8'h3C);
      fsa_core_model_inst.sfr_rd(`FSA_ADR_ADRL, v);
      chk("addr low", v, 8'h3C);
      // a frozen block must ignore a write strobe
      @(posedge clk_in);
      ce_in <= 1'b0;
      fsa_core_model_inst.sfr_wr(`FSA_ADR_ADRL, 8'h77);
      @(posedge clk_in);
      ce_in <= 1'b1;
      fsa_core_model_inst.sfr_rd(`FSA_ADR_ADRL, v);
      chk("frozen write", v, 8'h3C);
      rdback(16'h0201, `FSA_ERASED);
      op(K, `FSA_CMD_WRITE, 16'h0201, 8'h5A, `FSA_RES_OK);
      rdback(16'h0201, 8'h5A);
      op(K, `FSA_CMD_WRITE, 16'h0201, 8'hF0, `FSA_RES_OK);
      rdback(16'h0201, 8'h50);
      op(K, `FSA_CMD_VERIFY, 16'h0201, 8'h50, `FSA_RES_OK);
      op(K, `FSA_CMD_VERIFY, 16'h0201, 8'h51, `FSA_RES_FAIL);
      op(8'h00, `FSA_CMD_WRITE, 16'h0201, 8'h00, `FSA_RES_FAIL);
      op(K, 8'h07, 16'h0000, 8'h00, `FSA_RES_FAIL);
      rdback(16'h0201, 8'h50);
      op(K, `FSA_CMD_READ, `FSA_FW_BASE, 8'h00, `FSA_RES_FAIL);
      op(K, `FSA_CMD_WRITE, 16'hFFFF, 8'h00, `FSA_RES_FAIL);
      op(K, `FSA_CMD_ERASE_PG, `FSA_FW_BASE, 8'h00, `FSA_RES_FAIL);
      op(K, `FSA_CMD_WRITE, 16'h01FF, 8'h00, `FSA_RES_OK);
      op(K, `FSA_CMD_ERASE_PG, 16'h03FF, 8'h00, `FSA_RES_OK);
      rdback(16'h0201, `FSA_ERASED);
      rdback(16'h01FF, 8'h00);
      fsa_core_model_inst.sfr_wr(`FSA_ADR_PKEY, 8'h00);
      op(K, `FSA_CMD_WRITE, `FSA_WP_BASE, 8'hFD, `FSA_RES_FAIL);
      fsa_core_model_inst.sfr_wr(`FSA_ADR_PKEY, `FSA_RST_PKEY);
      op(K, `FSA_CMD_WRITE, `FSA_RP_BASE, 8'hFE, `FSA_RES_OK);
      op(K, `FSA_CMD_WRITE, `FSA_WP_BASE, 8'hFD, `FSA_RES_OK);
      op(K, `FSA_CMD_WRITE, `FSA_RSV_LAST, 8'hF7, `FSA_RES_OK);
      op(K, `FSA_CMD_WRITE, 16'h0300, 8'h00, `FSA_RES_FAIL);
      op(K, `FSA_CMD_ERASE_PG, 16'h0200, 8'h00, `FSA_RES_FAIL);
      op(K, `FSA_CMD_READ, 16'h01FF, 8'h00, `FSA_RES_FAIL);
      rdback(16'h0800, `FSA_ERASED);
      op(K, `FSA_CMD_WRITE, 16'hF5FF, 8'h12, `FSA_RES_OK);
      rdback(16'hF5FF, 8'h12);
      op(K, `FSA_CMD_WRITE, 16'hF600, 8'h00, `FSA_RES_FAIL);
      // mass erase clears open pages and skips the protected top page
      op(K, `FSA_CMD_ERASE_AL, 16'h0000, 8'h00, `FSA_RES_OK);
      rdback(16'hF5FF, `FSA_ERASED);
      rdback(`FSA_RSV_LAST, 8'hF7);
      finish_test();
   end
endmodule
